// *** fpocl_pkg.sv ***
`default_nettype none
package fpocl_pkg;
    // operand formats
    typedef enum logic [1:0] {
        FPOCL_FMT_SINGLE = 2'b00,
        FPOCL_FMT_DOUBLE = 2'b01,
        FPOCL_FMT_QUAD = 2'b10
    } fpocl_fmt_type;

    // operand class, one-hot free binary code
    typedef enum logic [2:0] {
        FPOCL_CLS_NORMAL = 3'b000,
        FPOCL_CLS_SUBNORMAL = 3'b001,
        FPOCL_CLS_ZERO = 3'b010,
        FPOCL_CLS_INFINITY = 3'b011,
        FPOCL_CLS_SNAN = 3'b100,
        FPOCL_CLS_QNAN = 3'b101
    } fpocl_class_type;

    // field layout, single
    localparam int SP_WIDTH = 32;
    localparam int SP_EXP_W = 8;
    localparam int SP_FRAC_W = 23;
    localparam int SP_SIGN_POS = 31;
    localparam int SP_EXP_LSB = 23;
    // field layout, double
    localparam int DP_WIDTH = 64;
    localparam int DP_EXP_W = 11;
    localparam int DP_FRAC_W = 52;
    localparam int DP_SIGN_POS = 63;
    localparam int DP_EXP_LSB = 52;
    // field layout, quad
    localparam int QP_WIDTH = 128;
    localparam int QP_EXP_W = 15;
    localparam int QP_FRAC_W = 112;
    localparam int QP_SIGN_POS = 127;
    localparam int QP_EXP_LSB = 112;
    localparam int QP_TOP_FRAC_W = 16;
    localparam int REG_W = 32;

    // biases and extremes (true exponents, 16-bit signed; all-ones biased exponent codes, 15-bit unsigned)
    localparam logic signed [15:0] SP_BIAS = 16'sh007f;
    localparam logic signed [15:0] DP_BIAS = 16'sh03ff;
    localparam logic signed [15:0] QP_BIAS = 16'sh3fff;
    localparam logic signed [15:0] SP_EMIN = -16'sh007e;
    localparam logic signed [15:0] SP_EMAX = 16'sh007f;
    localparam logic signed [15:0] DP_EMIN = -16'sh03fe;
    localparam logic signed [15:0] QP_EMIN = -16'sh3ffe;
    localparam logic [14:0] SP_EXP_MAX = 15'h00ff;
    localparam logic [14:0] DP_EXP_MAX = 15'h07ff;
    localparam logic [14:0] QP_EXP_MAX = 15'h7fff;

    // address and register numbering
    localparam int ADDR_W = 32;
    localparam int REGNUM_W = 5;
    localparam int FRAC_BUS_W = 112;

    // access sizes in bytes, log2
    typedef enum logic [2:0] {
        FPOCL_SZ_BYTE = 3'b000,
        FPOCL_SZ_HALF = 3'b001,
        FPOCL_SZ_WORD = 3'b010,
        FPOCL_SZ_DOUBLE = 3'b011,
        FPOCL_SZ_QUAD = 3'b100
    } fpocl_size_type;
endpackage
`default_nettype wire

// *** fpocl_field_split.sv ***
`default_nettype none
// combinational field extraction, all formats widened to quad-sized fields
module fpocl_field_split
    import fpocl_pkg::*;
(
    // operand
    input wire logic [fpocl_pkg::QP_WIDTH-1:0] operand_i,
    input wire fpocl_pkg::fpocl_fmt_type fmt_i,
    // fields
    output logic sign_o,
    output logic [14:0] exp_o,
    output logic [fpocl_pkg::FRAC_BUS_W-1:0] frac_o,
    output logic exp_all_ones_o
);
    // single and double sit in the low bits, left-justified fraction
    wire [SP_FRAC_W-1:0] sp_frac = operand_i[SP_FRAC_W-1:0];
    wire [DP_FRAC_W-1:0] dp_frac = operand_i[DP_FRAC_W-1:0];
    wire [QP_FRAC_W-1:0] qp_frac = operand_i[QP_FRAC_W-1:0];

    always_comb begin
        sign_o = 1'b0;
        exp_o = '0;
        frac_o = '0;
        exp_all_ones_o = 1'b0;
        case (fmt_i)
            FPOCL_FMT_SINGLE: begin
                sign_o = operand_i[SP_SIGN_POS];
                exp_o = {7'h00, operand_i[SP_EXP_LSB +: SP_EXP_W]};
                frac_o = {sp_frac, {(FRAC_BUS_W-SP_FRAC_W){1'b0}}};
                exp_all_ones_o = (exp_o == SP_EXP_MAX);
            end
            FPOCL_FMT_DOUBLE: begin
                sign_o = operand_i[DP_SIGN_POS];
                exp_o = {4'h0, operand_i[DP_EXP_LSB +: DP_EXP_W]};
                frac_o = {dp_frac, {(FRAC_BUS_W-DP_FRAC_W){1'b0}}};
                exp_all_ones_o = (exp_o == DP_EXP_MAX);
            end
            default: begin
                sign_o = operand_i[QP_SIGN_POS];
                exp_o = operand_i[QP_EXP_LSB +: QP_EXP_W];
                frac_o = qp_frac;
                exp_all_ones_o = (exp_o == QP_EXP_MAX);
            end
        endcase
    end
endmodule
`default_nettype wire

// *** fpocl_classifier.sv ***
`default_nettype none
module fpocl_classifier
    import fpocl_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // operand classification request
    input wire logic op_valid_i,
    input wire logic [fpocl_pkg::QP_WIDTH-1:0] operand_i,
    input wire fpocl_pkg::fpocl_fmt_type fmt_i,
    input wire logic float_operate_instruction_i,
    // memory access check request
    input wire logic mem_valid_i,
    input wire logic mem_load_i,
    input wire logic [fpocl_pkg::ADDR_W-1:0] mem_addr_i,
    input wire fpocl_pkg::fpocl_size_type mem_size_i,
    input wire logic [fpocl_pkg::REGNUM_W-1:0] mem_rd_i,
    // classification result
    output logic res_valid_o,
    output fpocl_pkg::fpocl_class_type class_o,
    output logic sign_o,
    output logic hidden_bit_o,
    output logic signed [15:0] true_exp_o,
    output logic [fpocl_pkg::FRAC_BUS_W-1:0] frac_o,
    output logic invalid_op_o,
    output logic fp_exception_trap_o,
    // quad register image, first register holds the top
    output logic [fpocl_pkg::REG_W-1:0] quad_reg0_o,
    output logic [fpocl_pkg::REG_W-1:0] quad_reg1_o,
    output logic [fpocl_pkg::REG_W-1:0] quad_reg2_o,
    output logic [fpocl_pkg::REG_W-1:0] quad_reg3_o,
    // memory access result
    output logic mem_res_valid_o,
    output logic misaligned_trap_o,
    output logic [fpocl_pkg::REGNUM_W-1:0] mem_rd_o,
    output logic [3:0] msb_lane_o
);
    import fpocl_pkg::*;

    logic sgn;
    logic [14:0] bexp;
    logic [FRAC_BUS_W-1:0] frac;
    logic exp_max;

    fpocl_field_split u_split (
        .operand_i(operand_i),
        .fmt_i(fmt_i),
        .sign_o(sgn),
        .exp_o(bexp),
        .frac_o(frac),
        .exp_all_ones_o(exp_max)
    );

    // bias and minimum true exponent per format
    function automatic logic signed [15:0] bias_of(input fpocl_fmt_type f);
        case (f)
            FPOCL_FMT_SINGLE: bias_of = SP_BIAS;
            FPOCL_FMT_DOUBLE: bias_of = DP_BIAS;
            default: bias_of = QP_BIAS;
        endcase
    endfunction

    function automatic logic signed [15:0] emin_of(input fpocl_fmt_type f);
        case (f)
            FPOCL_FMT_SINGLE: emin_of = SP_EMIN;
            FPOCL_FMT_DOUBLE: emin_of = DP_EMIN;
            default: emin_of = QP_EMIN;
        endcase
    endfunction

    wire exp_zero = (bexp == 15'h0000);
    wire frac_zero = (frac == '0);
    wire is_nan = exp_max && !frac_zero;
    wire is_snan = is_nan && !frac[FRAC_BUS_W-1];
    wire is_qnan = is_nan && frac[FRAC_BUS_W-1];
    // reserved code 3 splits as quad but is not trapped
    wire is_quad = (fmt_i == FPOCL_FMT_QUAD);

    fpocl_class_type next_class;
    assign next_class = (exp_zero && frac_zero) ? FPOCL_CLS_ZERO :
        (exp_zero) ? FPOCL_CLS_SUBNORMAL :
        (exp_max && frac_zero) ? FPOCL_CLS_INFINITY :
        is_snan ? FPOCL_CLS_SNAN :
        is_qnan ? FPOCL_CLS_QNAN : FPOCL_CLS_NORMAL;

    // subnormal uses minimum exponent; normal subtracts bias
    wire signed [15:0] next_true_exp = exp_zero ? emin_of(fmt_i) :
        16'($signed({1'b0, bexp}) - bias_of(fmt_i));
    wire next_hidden = !exp_zero && !exp_max;
    // quad operate traps and suppresses invalid; res_valid and class still register
    wire next_fpx_trap = op_valid_i && float_operate_instruction_i && is_quad;
    // qnan raises nothing: only snan feeds invalid
    wire next_invalid = op_valid_i && !next_fpx_trap && is_snan;

    // quad word split, big-endian register order
    wire [REG_W-1:0] next_q0 = operand_i[QP_WIDTH-1 -: REG_W];
    wire [REG_W-1:0] next_q1 = operand_i[QP_WIDTH-1-REG_W -: REG_W];
    wire [REG_W-1:0] next_q2 = operand_i[QP_WIDTH-1-2*REG_W -: REG_W];
    wire [REG_W-1:0] next_q3 = operand_i[REG_W-1:0];

    // alignment: low size bits of the address must be zero
    wire [3:0] align_mask = 4'((5'h01 << mem_size_i) - 5'h01);
    wire next_misaligned = mem_valid_i && ((mem_addr_i[3:0] & align_mask) != 4'h0);
    // pair and quad loads drop the odd bit of the destination
    wire even_rd = mem_load_i && (mem_size_i == FPOCL_SZ_DOUBLE || mem_size_i == FPOCL_SZ_QUAD);
    wire [REGNUM_W-1:0] next_rd = even_rd ? {mem_rd_i[REGNUM_W-1:1], 1'b0} : mem_rd_i;
    // byte lane of the most significant byte is the address itself
    wire [3:0] next_lane = mem_addr_i[3:0];

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            res_valid_o <= 1'b0;
            class_o <= FPOCL_CLS_ZERO;
            sign_o <= 1'b0;
            hidden_bit_o <= 1'b0;
            true_exp_o <= 16'sh0000;
            frac_o <= '0;
            invalid_op_o <= 1'b0;
            fp_exception_trap_o <= 1'b0;
        end else begin
            res_valid_o <= op_valid_i;
            class_o <= next_class;
            sign_o <= sgn;
            hidden_bit_o <= next_hidden;
            true_exp_o <= next_true_exp;
            frac_o <= frac;
            invalid_op_o <= next_invalid;
            fp_exception_trap_o <= next_fpx_trap;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            quad_reg0_o <= '0;
            quad_reg1_o <= '0;
            quad_reg2_o <= '0;
            quad_reg3_o <= '0;
        end else begin
            quad_reg0_o <= next_q0;
            quad_reg1_o <= next_q1;
            quad_reg2_o <= next_q2;
            quad_reg3_o <= next_q3;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mem_res_valid_o <= 1'b0;
            misaligned_trap_o <= 1'b0;
            mem_rd_o <= '0;
            msb_lane_o <= 4'h0;
        end else begin
            mem_res_valid_o <= mem_valid_i;
            misaligned_trap_o <= next_misaligned;
            mem_rd_o <= next_rd;
            msb_lane_o <= next_lane;
        end
    end

    // checks
    a_snan_invalid: assert property (@(posedge clk_i) disable iff (!rstn_i)
        res_valid_o && class_o == FPOCL_CLS_SNAN && !fp_exception_trap_o |-> invalid_op_o)
        else $error("snan without invalid");
    a_qnan_quiet: assert property (@(posedge clk_i) disable iff (!rstn_i)
        class_o == FPOCL_CLS_QNAN |-> !invalid_op_o)
        else $error("qnan raised invalid");
    a_quad_op_trap: assert property (@(posedge clk_i) disable iff (!rstn_i)
        op_valid_i && float_operate_instruction_i && fmt_i == FPOCL_FMT_QUAD
        |=> fp_exception_trap_o && !invalid_op_o)
        else $error("quad operate not trapped");
    a_no_sd_trap: assert property (@(posedge clk_i) disable iff (!rstn_i)
        fmt_i != FPOCL_FMT_QUAD |=> !fp_exception_trap_o)
        else $error("single or double trapped");
    a_zero_class: assert property (@(posedge clk_i) disable iff (!rstn_i)
        class_o == FPOCL_CLS_ZERO |-> frac_o == '0 && !hidden_bit_o)
        else $error("zero with fraction");
    a_sp_exp_range: assert property (@(posedge clk_i) disable iff (!rstn_i)
        fmt_i == FPOCL_FMT_SINGLE && next_class == FPOCL_CLS_NORMAL
        |=> true_exp_o >= SP_EMIN && true_exp_o <= SP_EMAX && hidden_bit_o)
        else $error("single exponent out of range");
    a_sub_minexp: assert property (@(posedge clk_i) disable iff (!rstn_i)
        next_class == FPOCL_CLS_SUBNORMAL |=> true_exp_o == emin_of($past(fmt_i)))
        else $error("subnormal exponent wrong");
    a_dp_nan_kind: assert property (@(posedge clk_i) disable iff (!rstn_i)
        fmt_i == FPOCL_FMT_DOUBLE && &operand_i[DP_EXP_LSB +: DP_EXP_W] && operand_i[DP_FRAC_W-1:0] != '0
        |=> class_o == ($past(operand_i[DP_FRAC_W-1]) ? FPOCL_CLS_QNAN : FPOCL_CLS_SNAN))
        else $error("double nan kind wrong");
    a_qp_inf_sign: assert property (@(posedge clk_i) disable iff (!rstn_i)
        fmt_i == FPOCL_FMT_QUAD && &operand_i[QP_EXP_LSB +: QP_EXP_W] && operand_i[QP_FRAC_W-1:0] == '0
        |=> class_o == FPOCL_CLS_INFINITY && sign_o == $past(operand_i[QP_SIGN_POS]))
        else $error("quad infinity misclassified");
    a_quad_align: assert property (@(posedge clk_i) disable iff (!rstn_i)
        mem_valid_i && mem_size_i == FPOCL_SZ_QUAD && mem_addr_i[3:0] != 4'h0
        |=> misaligned_trap_o && mem_res_valid_o)
        else $error("misaligned quad not trapped");
    a_even_dest: assert property (@(posedge clk_i) disable iff (!rstn_i)
        mem_valid_i && mem_load_i && mem_size_i == FPOCL_SZ_QUAD |=> !mem_rd_o[0])
        else $error("quad destination odd");
    a_quad_split: assert property (@(posedge clk_i) disable iff (!rstn_i)
        1'b1 |=> quad_reg0_o[REG_W-2 -: QP_EXP_W] == $past(operand_i[QP_EXP_LSB +: QP_EXP_W]))
        else $error("quad exponent misplaced");
endmodule
`default_nettype wire

// *** fpocl_iu_model.sv ***
`default_nettype none
// issuing side: random memory accesses, aligned unless told to misbehave
module fpocl_iu_model
    import fpocl_pkg::*;
(
    // clock, reset and control
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic go_i,
    input wire logic bad_i,
    input wire logic [31:0] rnd_i,
    // access request
    output logic mem_valid_o,
    output logic mem_load_o,
    output logic [fpocl_pkg::ADDR_W-1:0] mem_addr_o,
    output fpocl_pkg::fpocl_size_type mem_size_o,
    output logic [fpocl_pkg::REGNUM_W-1:0] mem_rd_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import fpocl_pkg::*;
    // sizes 5..7 fold onto quad, so quad accesses come often
    wire logic [2:0] sz = (rnd_i[2:0] > 3'h4) ? 3'h4 : rnd_i[2:0];
    wire logic [31:0] mask = (32'h1 << sz) - 32'h1;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mem_valid_o <= 1'b0;
            mem_load_o <= 1'b0;
            mem_addr_o <= 32'h0;
            mem_size_o <= FPOCL_SZ_BYTE;
            mem_rd_o <= 5'h0;
        end else begin
            mem_valid_o <= go_i & rnd_i[3];
            mem_load_o <= rnd_i[4];
            mem_size_o <= fpocl_size_type'(sz);
            mem_rd_o <= rnd_i[9:5];
            // idle address keeps toggling so a stale value never looks valid
            if (!go_i) begin
                mem_addr_o <= ~mem_addr_o;
            end else begin
                mem_addr_o <= bad_i ? rnd_i : (rnd_i & ~mask);
            end
        end
    end
endmodule
`default_nettype wire

// *** fp_operand_format_classifier_tb.sv ***
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_errors++; \
    $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module fp_operand_format_classifier_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fpocl_pkg::*;
    logic clk_i = 1'b0, rstn_i = 1'b0, op_valid = 1'b0, fop = 1'b0, go = 1'b0, bad = 1'b0;
    logic [127:0] operand = 128'h0;
    fpocl_fmt_type fmt = FPOCL_FMT_SINGLE;
    logic [31:0] st = 32'hbb36, rnd_m = 32'h0, pa;
    logic res_valid, sign, hidden, inv, trap, mvalid, mload, mres, mis, pv, pl;
    fpocl_class_type cls;
    logic signed [15:0] texp;
    logic [111:0] frac;
    logic [31:0] q0, q1, q2, q3, maddr;
    fpocl_size_type msize, ps;
    logic [4:0] mrd, rdo, pr;
    logic [3:0] lane;
    int n_errors = 0, n_checks = 0, cyc = 0;
    always #5 clk_i = ~clk_i;

    fpocl_iu_model fpocl_iu_model_i (.clk_i(clk_i), .rstn_i(rstn_i), .go_i(go), .bad_i(bad),
        .rnd_i(rnd_m), .mem_valid_o(mvalid), .mem_load_o(mload), .mem_addr_o(maddr),
        .mem_size_o(msize), .mem_rd_o(mrd));
    fpocl_classifier fpocl_classifier_i (.clk_i(clk_i), .rstn_i(rstn_i), .op_valid_i(op_valid),
        .operand_i(operand), .fmt_i(fmt), .float_operate_instruction_i(fop),
        .mem_valid_i(mvalid), .mem_load_i(mload), .mem_addr_i(maddr), .mem_size_i(msize),
        .mem_rd_i(mrd), .res_valid_o(res_valid), .class_o(cls), .sign_o(sign),
        .hidden_bit_o(hidden), .true_exp_o(texp), .frac_o(frac), .invalid_op_o(inv),
        .fp_exception_trap_o(trap), .quad_reg0_o(q0), .quad_reg1_o(q1), .quad_reg2_o(q2),
        .quad_reg3_o(q3), .mem_res_valid_o(mres), .misaligned_trap_o(mis), .mem_rd_o(rdo),
        .msb_lane_o(lane));

    function automatic logic [31:0] rnd();
        st = st ^ (st << 13);
        st = st ^ (st >> 17);
        st = st ^ (st << 5);
        return st;
    endfunction

    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc++;
        rnd_m <= rnd();
        if (cyc == 5000) begin
            n_errors++;
            summarize();
        end
    end

    // memory side: expectation from what the issuing model presented at the edge
    always @(posedge clk_i) begin
        pv = mvalid;
        pl = mload;
        pa = maddr;
        ps = msize;
        pr = mrd;
        #1;
        if (rstn_i) begin
            `CHK("mem_res_valid", pv, mres)
            `CHK("misaligned", pv && |(pa & ((32'h1 << ps) - 32'h1)), mis)
            `CHK("mem_rd", (pl && ps >= FPOCL_SZ_DOUBLE) ? {pr[4:1], 1'b0} : pr, rdo)
            `CHK("msb_lane", pa[3:0], lane)
        end
    end

    task automatic send(input logic [127:0] v, input fpocl_fmt_type f, input logic o);
        logic s;
        logic [14:0] e, mx;
        logic [111:0] fr;
        logic signed [15:0] b, mn, ex;
        fpocl_class_type c;
        @(posedge clk_i);
        op_valid <= 1'b1;
        operand <= v;
        fmt <= f;
        fop <= o;
        @(posedge clk_i);
        #1;
        case (f)
            FPOCL_FMT_SINGLE: begin
                s = v[31];
                e = {7'h0, v[30:23]};
                fr = {v[22:0], 89'h0};
                mx = SP_EXP_MAX;
                b = SP_BIAS;
                mn = SP_EMIN;
            end
            FPOCL_FMT_DOUBLE: begin
                s = v[63];
                e = {4'h0, v[62:52]};
                fr = {v[51:0], 60'h0};
                mx = DP_EXP_MAX;
                b = DP_BIAS;
                mn = DP_EMIN;
            end
            default: begin
                s = v[127];
                e = v[126:112];
                fr = v[111:0];
                mx = QP_EXP_MAX;
                b = QP_BIAS;
                mn = QP_EMIN;
            end
        endcase
        c = (e == 15'h0) ? ((fr == 112'h0) ? FPOCL_CLS_ZERO : FPOCL_CLS_SUBNORMAL) :
            (e == mx) ? ((fr == 112'h0) ? FPOCL_CLS_INFINITY :
            (fr[111] ? FPOCL_CLS_QNAN : FPOCL_CLS_SNAN)) : FPOCL_CLS_NORMAL;
        ex = (e == 15'h0) ? mn : $signed({1'b0, e}) - b;
        `CHK("res_valid", 1'b1, res_valid)
        `CHK("class", c, cls)
        `CHK("sign", s, sign)
        `CHK("hidden", c == FPOCL_CLS_NORMAL, hidden)
        `CHK("true_exp", ex, texp)
        `CHK("frac", fr, frac)
        `CHK("invalid", c == FPOCL_CLS_SNAN && !(o && f == FPOCL_FMT_QUAD), inv)
        `CHK("fp_trap", o && f == FPOCL_FMT_QUAD, trap)
        `CHK("quad_regs", v, {q0, q1, q2, q3})
    endtask

    initial begin
        logic [31:0] r;
        logic [127:0] v;
        repeat (6) @(posedge clk_i);
        `CHK("reset_class", FPOCL_CLS_ZERO, cls)
        `CHK("reset_valid", 1'b0, res_valid)
        rstn_i <= 1'b1;
        go <= 1'b1;
        send(128'h7fa00000, FPOCL_FMT_SINGLE, 1'b0);
        send(128'h7fc00000, FPOCL_FMT_SINGLE, 1'b1);
        send(128'h80000000, FPOCL_FMT_SINGLE, 1'b0);
        send(128'hff800000, FPOCL_FMT_SINGLE, 1'b0);
        send(128'h00000001, FPOCL_FMT_SINGLE, 1'b0);
        send(128'h7f7fffff, FPOCL_FMT_SINGLE, 1'b0);
        send(128'h00800000, FPOCL_FMT_SINGLE, 1'b0);
        send(128'h7ff0000000000001, FPOCL_FMT_DOUBLE, 1'b1);
        send({1'b1, 15'h7fff, 112'h0}, FPOCL_FMT_QUAD, 1'b0);
        send({1'b0, 15'h7fff, 112'h1}, FPOCL_FMT_QUAD, 1'b1);
        send({1'b0, 15'h7fff, 112'h1}, fpocl_fmt_type'(2'b11), 1'b0);
        for (int i = 0; i < 300; i++) begin
            r = rnd();
            v = {rnd(), rnd(), rnd(), rnd()};
            // pull exponents to the edges often, since that is where classes change
            if (!r[1]) begin
                v[30:23] = {8{r[0]}};
                v[62:52] = {11{r[0]}};
                v[126:112] = {15{r[0]}};
            end
            if (r[2]) begin
                v[22:0] = 23'h0;
                v[51:0] = 52'h0;
                v[111:0] = 112'h0;
            end
            if (i == 150) begin
                bad <= 1'b1;
            end
            send(v, fpocl_fmt_type'(r[4:3]), r[5]);
        end
        op_valid <= 1'b0;
        go <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        `CHK("idle_valid", 1'b0, res_valid)
        `CHK("idle_invalid", 1'b0, inv)
        summarize();
    end
endmodule
`default_nettype wire
